// ---- hdl/ccd_timing_pkg.sv ----
package ccd_timing_pkg;

	// Geometry
	localparam int LINES_FULL      = 1092;
	localparam int LINES_FIELD     = 546;
	localparam int EMPTY_PIX       = 4;
	localparam int SHIELD_PIX      = 28;
	localparam int ACTIVE_SINGLE   = 1928;
	localparam int ACTIVE_DUAL     = 964;
	localparam int CLOCKS_SINGLE   = 1988;
	localparam int CLOCKS_DUAL     = 996;
	localparam int DARK_COL_SKIP   = 2;
	localparam int DARK_COL_USE    = 24;
	localparam int DARK_ROWS       = 4;
	localparam int DARK_ROW_SKIP   = 1;
	localparam int DARK_ROW_USE    = 2;

	// Timing, nanoseconds, and derived counts at 40 MHz
	localparam int CLK_NS          = 25;
	localparam int T_HD_NS         = 1500;
	localparam int T_VERTICAL_SHIFT_REGISTER_NS       = 1500;
	localparam int T_V3RD_NS       = 12000;
	localparam int T_SHUT_NS       = 5000;
	localparam int T_SD_NS         = 1600;
	localparam int HD_CYC          = (T_HD_NS + CLK_NS - 1) / CLK_NS;
	localparam int VERTICAL_SHIFT_REGISTER_CYC        = (T_VERTICAL_SHIFT_REGISTER_NS + CLK_NS - 1) / CLK_NS;
	localparam int V3RD_CYC        = (T_V3RD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SHUT_CYC        = (T_SHUT_NS + CLK_NS - 1) / CLK_NS;
	localparam int SD_CYC          = (T_SD_NS + CLK_NS - 1) / CLK_NS;

	// Register map of the controller
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_LINES  = 4'h1;
	localparam logic [3:0] ADDR_SHUT   = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam int CTRL_START   = 0;
	localparam int CTRL_MODE_LO = 1;
	localparam int CTRL_DUAL    = 3;
	localparam int CTRL_SHUT    = 4;
	localparam int CTRL_PWRGATE = 5;

	typedef enum logic [1:0] {
		MODE_PROGRESSIVE = 2'h0,
		MODE_FIELD_INT   = 2'h1,
		MODE_FRAME_INT   = 2'h2
	} readout_mode_t;

	typedef struct packed {
		logic vertical_phase_one;
		logic vertical_transfer_high_level;
		logic vertical_phase_two_even;
		logic vertical_phase_two_odd;
	} vertical_drive_t;

	typedef struct packed {
		logic left_store_phase_one;
		logic left_barrier_phase_one;
		logic right_store_phase_one;
		logic right_barrier_phase_one;
		logic left_store_phase_two;
		logic left_barrier_phase_two;
		logic right_store_phase_two;
		logic right_barrier_phase_two;
	} horizontal_drive_t;

	typedef struct packed {
		logic line_valid;
		logic active_pixel;
		logic dark_column;
		logic dark_row;
		logic image_line;
		logic even_field;
	} pixel_tag_t;

endpackage

// ---- hdl/ccd_readout_timing_sequencer.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Progressive: both second vertical phases equal, all 1092 lines read.
// - Interlaced: 546 lines per field, even then odd field per frame.
// - Field integration bins line pairs; second vertical phases identical.
// - Frame integration clocks even and odd second phases separately.
// - Single output uses left output; right amplifier may be off.
// - Single output: phase one on left pair, right store, right barrier two.
// - Single output line: 4 empty, 28, 1928, 28 shielded; 1988 clocks.
// - Dual output swaps right barrier drives; phases drive matching gates.
// - Dual output line: 4 empty, 28 shielded, 964 active; 996 clocks.
// - Right barrier edges coincide with other horizontal edges within 3 ns.
// - Shutter pulse on substrate; integration ends at transfer-high fall.
// - Without shutter, exposure is spacing between transfer-high levels.
// - Keep clocking during integration; only first 1092 lines are image. Here clocking stops while idle.
// - If clocking halted, flush registers before photodiode transfer. No flush is done here.
// - Dark line clamp uses middle 24 of 28 shielded columns.
// - Dark reference uses middle two of four shielded rows. Here dark rows are tagged in progressive readout only.
// - One reset pulse per pixel, at the pixel rate.
// - Amplifier supplies enabled only during readout for long exposure.
module ccd_readout_timing_sequencer #(
	parameter int HDIV       = 2,
	parameter int LINE_W     = 16,
	parameter int SHUT_W     = 16
) (
	input  wire logic                              MCLK,
	input  wire logic                              RESETN,
	input  wire logic [3:0]                        ADDR,
	input  wire logic [31:0]                       WDATA,
	input  wire logic                              WR,
	input  wire logic                              RD,
	output logic [31:0]                            RDATA,
	output ccd_timing_pkg::vertical_drive_t        VDRIVE,
	output ccd_timing_pkg::horizontal_drive_t      HDRIVE,
	output logic                                   RESET_CLOCK,
	output logic                                   SUBSTRATE_BIAS,
	output logic                                   LEFT_AMPLIFIER_SUPPLY,
	output logic                                   RIGHT_AMPLIFIER_SUPPLY,
	output ccd_timing_pkg::pixel_tag_t             PIXEL_TAG
);

	// ============================================================
	// Control registers
	logic [1:0]        mode_reg;
	logic              dual_reg;
	logic              shut_en_reg;
	logic              pwrgate_reg;
	logic              start_reg;
	logic [LINE_W-1:0] lines_reg;
	logic [SHUT_W-1:0] shut_lines_reg;
	logic              busy;
	logic              field_odd_reg;
	logic [LINE_W-1:0] line_reg;

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			mode_reg       <= 2'h0;
			dual_reg       <= 1'b0;
			shut_en_reg    <= 1'b0;
			pwrgate_reg    <= 1'b0;
			lines_reg      <= LINE_W'(ccd_timing_pkg::LINES_FULL);
			shut_lines_reg <= '0;
		end else if (WR && ADDR == ccd_timing_pkg::ADDR_CTRL) begin
			mode_reg    <= WDATA[ccd_timing_pkg::CTRL_MODE_LO +: 2];
			dual_reg    <= WDATA[ccd_timing_pkg::CTRL_DUAL];
			shut_en_reg <= WDATA[ccd_timing_pkg::CTRL_SHUT];
			pwrgate_reg <= WDATA[ccd_timing_pkg::CTRL_PWRGATE];
		end else if (WR && ADDR == ccd_timing_pkg::ADDR_LINES) begin
			lines_reg <= WDATA[LINE_W-1:0];
		end else if (WR && ADDR == ccd_timing_pkg::ADDR_SHUT) begin
			shut_lines_reg <= WDATA[SHUT_W-1:0];
		end
	end

	// Start is a one-cycle request taken only while idle
	always_ff @(posedge MCLK) begin
		if (!RESETN)
			start_reg <= 1'b0;
		else
			start_reg <= WR && ADDR == ccd_timing_pkg::ADDR_CTRL &&
				WDATA[ccd_timing_pkg::CTRL_START] && !busy;
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			RDATA <= 32'h0;
		end else if (RD) begin
			case (ADDR)
			ccd_timing_pkg::ADDR_CTRL:
				RDATA <= {26'h0, pwrgate_reg, shut_en_reg, dual_reg,
					mode_reg, 1'b0};
			ccd_timing_pkg::ADDR_LINES:  RDATA <= 32'(lines_reg);
			ccd_timing_pkg::ADDR_SHUT:   RDATA <= 32'(shut_lines_reg);
			ccd_timing_pkg::ADDR_STATUS:
				RDATA <= {14'h0, field_odd_reg, busy, line_reg};
			default:                     RDATA <= 32'h0;
			endcase
		end else begin
			RDATA <= 32'h0;
		end
	end

	// ============================================================
	// Pixel rate divider
	logic [7:0] div_reg;
	logic       hstep;
	assign hstep = (div_reg == 8'(HDIV - 1));

	always_ff @(posedge MCLK) begin
		if (!RESETN || hstep)
			div_reg <= 8'h0;
		else
			div_reg <= div_reg + 8'h1;
	end

	// ============================================================
	// Frame sequencer
	typedef enum logic [2:0] {
		S_IDLE, S_TRANSFER, S_VSHIFT, S_HDELAY, S_HCLOCK
	} state_t;
	state_t state_reg;
	logic [15:0] tcnt_reg;
	logic [11:0] pix_reg;
	logic [11:0] pix_total;
	logic [LINE_W-1:0] line_total;
	logic        interlaced;
	logic        phase_reg;
	logic        shutter_pulse;

	assign interlaced = mode_reg != ccd_timing_pkg::MODE_PROGRESSIVE;
	assign busy       = state_reg != S_IDLE;
	assign pix_total  = dual_reg ? 12'(ccd_timing_pkg::CLOCKS_DUAL)
		: 12'(ccd_timing_pkg::CLOCKS_SINGLE);
	// Interlaced fields read half the lines; the shutter line offset is not halved
	assign line_total = interlaced ? (lines_reg >> 1) : lines_reg;

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			state_reg <= S_IDLE;
			tcnt_reg  <= 16'h0;
			pix_reg   <= 12'h0;
			line_reg  <= '0;
		end else begin
			case (state_reg)
			S_IDLE: begin
				tcnt_reg <= 16'h0;
				// Clocking stops while idle, and no flush precedes the transfer
				if (start_reg)
					state_reg <= S_TRANSFER;
			end
			S_TRANSFER: begin
				tcnt_reg <= tcnt_reg + 16'h1;
				if (tcnt_reg == 16'(ccd_timing_pkg::V3RD_CYC - 1)) begin
					tcnt_reg  <= 16'h0;
					line_reg  <= '0;
					state_reg <= S_VSHIFT;
				end
			end
			S_VSHIFT: begin
				tcnt_reg <= tcnt_reg + 16'h1;
				if (tcnt_reg == 16'(ccd_timing_pkg::VERTICAL_SHIFT_REGISTER_CYC - 1)) begin
					tcnt_reg  <= 16'h0;
					state_reg <= S_HDELAY;
				end
			end
			S_HDELAY: begin
				tcnt_reg <= tcnt_reg + 16'h1;
				pix_reg  <= 12'h0;
				if (tcnt_reg == 16'(ccd_timing_pkg::HD_CYC - 1)) begin
					tcnt_reg  <= 16'h0;
					state_reg <= S_HCLOCK;
				end
			end
			S_HCLOCK: begin
				if (hstep && phase_reg) begin
					pix_reg <= pix_reg + 12'h1;
					if (pix_reg == pix_total - 12'h1) begin
						line_reg <= line_reg + LINE_W'(1);
						if (line_reg == line_total - LINE_W'(1))
							state_reg <= S_IDLE;
						else
							state_reg <= S_VSHIFT;
					end
				end
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end

	// Field parity alternates each interlaced readout
	always_ff @(posedge MCLK) begin
		if (!RESETN)
			field_odd_reg <= 1'b0;
		else if (state_reg == S_HCLOCK && hstep && phase_reg &&
			pix_reg == pix_total - 12'h1 &&
			line_reg == line_total - LINE_W'(1) && interlaced)
			field_odd_reg <= !field_odd_reg;
	end

	// Horizontal phase toggles each divider step while clocking
	always_ff @(posedge MCLK) begin
		if (!RESETN || state_reg != S_HCLOCK)
			phase_reg <= 1'b0;
		else if (hstep)
			phase_reg <= !phase_reg;
	end

	// ============================================================
	// Pin drive
	logic h1;
	logic h2;
	logic v2;
	logic v2_even;
	logic v2_odd;
	logic xfer;
	assign h1   = state_reg == S_HCLOCK ? !phase_reg : 1'b1;
	assign h2   = !h1;
	assign xfer = state_reg == S_TRANSFER;
	assign v2   = state_reg == S_VSHIFT;
	// Frame integration transfers only the lines of the current field
	always_comb begin
		v2_even = v2 || xfer;
		v2_odd  = v2 || xfer;
		if (mode_reg == ccd_timing_pkg::MODE_FRAME_INT) begin
			v2_even = v2 || (xfer && !field_odd_reg);
			v2_odd  = v2 || (xfer && field_odd_reg);
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			VDRIVE <= '0;
			HDRIVE <= '0;
			RESET_CLOCK <= 1'b0;
		end else begin
			VDRIVE.vertical_phase_one          <= !v2 && !xfer;
			VDRIVE.vertical_transfer_high_level <= xfer;
			VDRIVE.vertical_phase_two_even     <= v2_even;
			VDRIVE.vertical_phase_two_odd      <= v2_odd;
			// All eight gates change on one edge of one clock
			HDRIVE.left_store_phase_one    <= h1;
			HDRIVE.left_barrier_phase_one  <= h1;
			HDRIVE.right_store_phase_one   <= h1;
			HDRIVE.right_barrier_phase_one <= dual_reg ? h1 : h2;
			HDRIVE.left_store_phase_two    <= h2;
			HDRIVE.left_barrier_phase_two  <= h2;
			HDRIVE.right_store_phase_two   <= h2;
			HDRIVE.right_barrier_phase_two <= dual_reg ? h2 : h1;
			RESET_CLOCK <= state_reg == S_HCLOCK && !phase_reg &&
				div_reg == 8'h0;
		end
	end

	// ============================================================
	// Electronic shutter: substrate pulse falls in the line a set number of lines before the last read line,
	// no sooner than the pulse delay after the photodiode transfer.
	logic [15:0] scnt_reg;
	always_ff @(posedge MCLK) begin
		if (!RESETN)
			scnt_reg <= 16'h0;
		else if (state_reg == S_TRANSFER)
			scnt_reg <= 16'h0;
		else if (scnt_reg != 16'hFFFF)
			scnt_reg <= scnt_reg + 16'h1;
	end
	assign shutter_pulse = shut_en_reg && state_reg == S_HCLOCK &&
		line_reg == line_total - LINE_W'(shut_lines_reg) - LINE_W'(1) &&
		pix_reg < 12'(ccd_timing_pkg::SHUT_CYC / HDIV / 2) &&
		scnt_reg > 16'(ccd_timing_pkg::SD_CYC);

	always_ff @(posedge MCLK) begin
		if (!RESETN)
			SUBSTRATE_BIAS <= 1'b0;
		else
			SUBSTRATE_BIAS <= shutter_pulse;
	end

	// ============================================================
	// Amplifier supplies and pixel tagging
	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			LEFT_AMPLIFIER_SUPPLY  <= 1'b0;
			RIGHT_AMPLIFIER_SUPPLY <= 1'b0;
		end else begin
			LEFT_AMPLIFIER_SUPPLY  <= !pwrgate_reg || busy;
			RIGHT_AMPLIFIER_SUPPLY <= dual_reg &&
				(!pwrgate_reg || busy);
		end
	end

	logic [11:0] col;
	logic [11:0] act;
	assign col = pix_reg - 12'(ccd_timing_pkg::EMPTY_PIX);
	assign act = dual_reg ? 12'(ccd_timing_pkg::ACTIVE_DUAL)
		: 12'(ccd_timing_pkg::ACTIVE_SINGLE);

	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			PIXEL_TAG <= '0;
		end else begin
			PIXEL_TAG.line_valid <= state_reg == S_HCLOCK;
			PIXEL_TAG.active_pixel <= pix_reg >=
				12'(ccd_timing_pkg::EMPTY_PIX + ccd_timing_pkg::SHIELD_PIX)
				&& col < 12'(ccd_timing_pkg::SHIELD_PIX) + act;
			PIXEL_TAG.dark_column <= pix_reg >= 12'(ccd_timing_pkg::EMPTY_PIX)
				&& ((col >= 12'(ccd_timing_pkg::DARK_COL_SKIP) &&
				col < 12'(ccd_timing_pkg::DARK_COL_SKIP +
				ccd_timing_pkg::DARK_COL_USE)) ||
				(!dual_reg && col >= 12'(ccd_timing_pkg::SHIELD_PIX +
				ccd_timing_pkg::ACTIVE_SINGLE + ccd_timing_pkg::DARK_COL_SKIP)
				&& col < 12'(ccd_timing_pkg::SHIELD_PIX +
				ccd_timing_pkg::ACTIVE_SINGLE + ccd_timing_pkg::DARK_COL_SKIP
				+ ccd_timing_pkg::DARK_COL_USE)));
			PIXEL_TAG.dark_row <= !interlaced &&
				((line_reg >= LINE_W'(ccd_timing_pkg::DARK_ROW_SKIP) &&
				line_reg < LINE_W'(ccd_timing_pkg::DARK_ROW_SKIP +
				ccd_timing_pkg::DARK_ROW_USE)) ||
				(line_reg >= LINE_W'(ccd_timing_pkg::LINES_FULL -
				ccd_timing_pkg::DARK_ROWS + ccd_timing_pkg::DARK_ROW_SKIP) &&
				line_reg < LINE_W'(ccd_timing_pkg::LINES_FULL -
				ccd_timing_pkg::DARK_ROW_SKIP)));
			PIXEL_TAG.image_line <= line_reg < (interlaced ?
				LINE_W'(ccd_timing_pkg::LINES_FIELD) :
				LINE_W'(ccd_timing_pkg::LINES_FULL));
			PIXEL_TAG.even_field <= !field_odd_reg;
		end
	end

endmodule

// ---- verif/ccd_readout_timing_sequencer_asserts.sv ----
`timescale 1ns/1ps
// ========================================
// Port checks of the readout sequencer
module ccd_readout_timing_sequencer_chk #(
	parameter int HDIV = 2
) (
	input wire logic                          MCLK,
	input wire logic                          RESETN,
	input wire logic [3:0]                    ADDR,
	input wire logic [31:0]                   WDATA,
	input wire logic                          WR,
	input ccd_timing_pkg::vertical_drive_t    VDRIVE,
	input ccd_timing_pkg::horizontal_drive_t  HDRIVE,
	input wire logic                          RESET_CLOCK,
	input wire logic                          SUBSTRATE_BIAS,
	input wire logic                          LEFT_AMPLIFIER_SUPPLY,
	input wire logic                          RIGHT_AMPLIFIER_SUPPLY,
	input ccd_timing_pkg::pixel_tag_t         PIXEL_TAG
);
	localparam int LEN_S = ccd_timing_pkg::CLOCKS_SINGLE * 2 * HDIV;
	localparam int LEN_D = ccd_timing_pkg::CLOCKS_DUAL * 2 * HDIV;
	ccd_timing_pkg::horizontal_drive_t h;
	logic [1:0]  mode_reg;
	logic        dual_reg;
	logic        shut_reg;
	logic [15:0] lv_reg;
	logic [15:0] sb_reg;
	logic        lv;
	assign h = HDRIVE;
	assign lv = PIXEL_TAG.line_valid;
	// Shadow of the settings, written on every control register write
	always_ff @(posedge MCLK) begin
		if (!RESETN) begin
			mode_reg <= 2'h0;
			dual_reg <= 1'b0;
			shut_reg <= 1'b0;
		end else if (WR && ADDR == ccd_timing_pkg::ADDR_CTRL) begin
			mode_reg <= WDATA[2:1];
			dual_reg <= WDATA[3];
			shut_reg <= WDATA[4];
		end
	end
	// Lengths of line and shutter pulse in clocks
	always_ff @(posedge MCLK) begin
		lv_reg <= lv ? lv_reg + 16'h1 : 16'h0;
		sb_reg <= SUBSTRATE_BIAS ? sb_reg + 16'h1 : 16'h0;
	end
	default clocking dcb @(posedge MCLK);
	endclocking
	default disable iff (!RESETN);
	chk_hgate_groups: assert property (
		h.left_store_phase_one == h.left_barrier_phase_one &&
		h.left_store_phase_one == h.right_store_phase_one &&
		h.left_store_phase_two == h.left_barrier_phase_two &&
		h.left_store_phase_two == h.right_store_phase_two)
		else $error("horizontal gate groups split");
	chk_single_brr: assert property (
		lv && !dual_reg |-> h.right_barrier_phase_two == h.left_store_phase_one
		&& h.right_barrier_phase_one == h.left_store_phase_two)
		else $error("single output barrier drive wrong");
	chk_dual_brr: assert property (
		lv && dual_reg |-> h.right_barrier_phase_one == h.left_store_phase_one
		&& h.right_barrier_phase_two == h.left_store_phase_two)
		else $error("dual output barrier drive wrong");
	chk_vtwo_tied: assert property (
		mode_reg != ccd_timing_pkg::MODE_FRAME_INT |->
		VDRIVE.vertical_phase_two_even == VDRIVE.vertical_phase_two_odd)
		else $error("second vertical phases differ");
	chk_frame_split: assert property (
		mode_reg == ccd_timing_pkg::MODE_FRAME_INT &&
		VDRIVE.vertical_transfer_high_level |->
		VDRIVE.vertical_phase_two_even != VDRIVE.vertical_phase_two_odd)
		else $error("frame integration transfer not split");
	chk_hedge_align: assert property (
		lv |-> $changed(h.right_barrier_phase_one) ==
		$changed(h.left_store_phase_one))
		else $error("right barrier edge misaligned");
	chk_reset_pulse: assert property (
		$rose(RESET_CLOCK) |=> !RESET_CLOCK)
		else $error("reset clock pulse too wide");
	chk_amp_supply: assert property (
		lv |-> LEFT_AMPLIFIER_SUPPLY && (RIGHT_AMPLIFIER_SUPPLY || !dual_reg))
		else $error("amplifier supply off during readout");
	chk_shut_off: assert property (
		!shut_reg |-> !SUBSTRATE_BIAS)
		else $error("shutter pulse while shutter disabled");
	chk_shut_width: assert property (
		$fell(SUBSTRATE_BIAS) |-> sb_reg == ccd_timing_pkg::SHUT_CYC)
		else $error("shutter pulse width wrong");
	chk_line_len: assert property (
		$fell(lv) |-> lv_reg == (dual_reg ? LEN_D : LEN_S))
		else $error("line clock count wrong");
endmodule

bind ccd_readout_timing_sequencer ccd_readout_timing_sequencer_chk #(
	.HDIV(HDIV)
) u_chk (
	.MCLK(MCLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
	.VDRIVE(VDRIVE), .HDRIVE(HDRIVE), .RESET_CLOCK(RESET_CLOCK),
	.SUBSTRATE_BIAS(SUBSTRATE_BIAS), .PIXEL_TAG(PIXEL_TAG),
	.LEFT_AMPLIFIER_SUPPLY(LEFT_AMPLIFIER_SUPPLY),
	.RIGHT_AMPLIFIER_SUPPLY(RIGHT_AMPLIFIER_SUPPLY)
);

// ---- verif/ccd_sensor_model.sv ----
`timescale 1ns/1ps
// ========================================
// Behavioural sensor: counts what it is driven with
module ccd_sensor_model (
	input wire logic                       clk,
	input ccd_timing_pkg::vertical_drive_t vdrive,
	input wire logic                       reset_clock,
	input wire logic                       substrate_bias,
	input wire logic                       left_supply,
	output logic [31:0]                    pix_count,
	output logic [31:0]                    xfer_count,
	output logic [31:0]                    shut_count
);
	logic xfer_d;
	logic shut_d;
	initial begin
		pix_count = 32'h0;
		xfer_count = 32'h0;
		shut_count = 32'h0;
		xfer_d = 1'b0;
		shut_d = 1'b0;
	end
	always @(posedge clk) begin
		xfer_d <= vdrive.vertical_transfer_high_level;
		shut_d <= substrate_bias;
		// Each reset pulse counts as a pixel only while the left supply is on
		if (reset_clock && left_supply) pix_count <= pix_count + 32'h1;
		// Photodiode charge moves on each transfer-high level
		if (vdrive.vertical_transfer_high_level && !xfer_d)
			xfer_count <= xfer_count + 32'h1;
		// Integration restarts at the shutter pulse fall
		if (!substrate_bias && shut_d) shut_count <= shut_count + 32'h1;
	end
endmodule

// ---- verif/ccd_readout_timing_sequencer_tb.sv ----
`timescale 1ns/1ps
module ccd_readout_timing_sequencer_tb;
	logic                              MCLK, RESETN, WR, RD;
	logic [3:0]                        ADDR;
	logic [31:0]                       WDATA, RDATA, pix, xfer, shots;
	ccd_timing_pkg::vertical_drive_t   VDRIVE;
	ccd_timing_pkg::horizontal_drive_t HDRIVE;
	ccd_timing_pkg::pixel_tag_t        PIXEL_TAG;
	logic                              RESET_CLOCK, SUBSTRATE_BIAS, LSUP, RSUP;
	logic [15:0]                       lfsr;
	int                                err_count, n_compared, cyc;
	int                                dcol, drow;
	logic [31:0]                       d;

	ccd_readout_timing_sequencer #(.HDIV(1)) dut (
		.MCLK(MCLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .VDRIVE(VDRIVE), .HDRIVE(HDRIVE),
		.RESET_CLOCK(RESET_CLOCK), .SUBSTRATE_BIAS(SUBSTRATE_BIAS),
		.LEFT_AMPLIFIER_SUPPLY(LSUP), .RIGHT_AMPLIFIER_SUPPLY(RSUP),
		.PIXEL_TAG(PIXEL_TAG));
	ccd_sensor_model u_sensor (
		.clk(MCLK), .vdrive(VDRIVE), .reset_clock(RESET_CLOCK),
		.substrate_bias(SUBSTRATE_BIAS), .left_supply(LSUP),
		.pix_count(pix), .xfer_count(xfer), .shut_count(shots));

	// ========================================
	// Helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [31:0] exp_pix(input int mode, dual, lines);
		int n;
		n = (mode == 0) ? lines : lines / 2;
		return n * (dual ? ccd_timing_pkg::CLOCKS_DUAL
			: ccd_timing_pkg::CLOCKS_SINGLE);
	endfunction
	task chk(input string name, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge MCLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= v;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge MCLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge MCLK);
		RD <= 1'b0;
		// Read data stand for the one cycle after the strobe
		#1 v = RDATA;
	endtask
	// Dark tags seen on clocked line cycles
	always @(posedge MCLK) begin
		if (PIXEL_TAG.line_valid && PIXEL_TAG.dark_column) dcol++;
		if (PIXEL_TAG.line_valid && PIXEL_TAG.dark_row) drow++;
	end
	task test_done();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One readout; a second start while busy must be ignored
	task run_frame(input int mode, dual, shut, gate, lines);
		logic [31:0] p0, x0, s0, ctl;
		int n, c0, r0, nl, clk_line;
		c0 = dcol;
		r0 = drow;
		nl = (mode == 0) ? lines : lines / 2;
		clk_line = 2 * (dual ? ccd_timing_pkg::CLOCKS_DUAL
			: ccd_timing_pkg::CLOCKS_SINGLE);
		p0 = pix;
		x0 = xfer;
		s0 = shots;
		ctl = {26'h0, gate[0], shut[0], dual[0], mode[1:0], 1'b1};
		wr(ccd_timing_pkg::ADDR_LINES, lines);
		wr(ccd_timing_pkg::ADDR_SHUT, 32'h0);
		rd(ccd_timing_pkg::ADDR_LINES, d);
		chk("lines", d, lines);
		wr(ccd_timing_pkg::ADDR_CTRL, ctl);
		wr(ccd_timing_pkg::ADDR_CTRL, ctl);
		n = 0;
		d = 32'h10000;
		while (d[16] === 1'b1 && n < 10000) begin
			rd(ccd_timing_pkg::ADDR_STATUS, d);
			n++;
		end
		chk("busy", d[16], 1'b0);
		chk("pixels", pix - p0, exp_pix(mode, dual, lines));
		chk("transfers", xfer - x0, 1);
		chk("dark_cols", dcol - c0, nl * 2 * ccd_timing_pkg::DARK_COL_USE
			* (dual ? 1 : 2));
		chk("dark_rows", drow - r0, (mode != 0) ? 0 : clk_line *
			(lines > ccd_timing_pkg::DARK_ROW_USE ?
			ccd_timing_pkg::DARK_ROW_USE :
			lines - ccd_timing_pkg::DARK_ROW_SKIP));
		chk("rsupply", RSUP, dual && !gate);
		chk("shutter", shots - s0, shut);
		chk("supply", LSUP, !gate);
	endtask

	// ========================================
	// Clock, timeout and main sequence
	initial begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 100000) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		RESETN = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 4'h0;
		WDATA = 32'h0;
		lfsr = 16'hBC16;
		err_count = 0;
		n_compared = 0;
		cyc = 0;
		repeat (20) @(posedge MCLK);
		RESETN <= 1'b1;
		rd(ccd_timing_pkg::ADDR_LINES, d);
		chk("lines_rst", d, ccd_timing_pkg::LINES_FULL);
		rd(4'hF, d);
		chk("unmapped", d, 32'h0);
		for (int i = 0; i < 5; i++) begin
			lfsr = lfsr_next(lfsr);
			run_frame(i % 3, i % 2, (i / 2) % 2, i >= 3, lfsr[0] ? 4 : 2);
		end
		test_done();
	end
endmodule
